// ==== logic/resolver_pkg.sv ====
package resolver_pkg;

   // ************************************************************
   // register map and layout
   // ************************************************************
   localparam logic [15:0] CTRL_ADDR = 16'h103C;
   localparam logic [15:0] SENSE_ADDR = 16'h1040;
   localparam logic [15:0] STATUS_ADDR = 16'h1044;
   localparam int BIT_BOOT = 7;
   localparam int BIT_SPEC = 6;
   localparam int BIT_MODE_A = 5;
   localparam int BIT_VIS = 4;
   localparam int BIT_EDGE = 0;
   localparam int BIT_LATCH = 1;
   localparam int BIT_WVALID = 31;
   localparam int BIT_WRESET = 24;
   localparam int SRC_LSB = 16;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [3:0] PSEL_RST = 4'h6;
   // upper control nibble: boot, special, mode a, visibility
   localparam logic [3:0] MODE_RST_SINGLE = 4'h0;
   localparam logic [3:0] MODE_RST_EXPANDED = 4'h2;
   localparam logic [3:0] MODE_RST_BOOT = 4'hC;
   localparam logic [3:0] MODE_RST_TEST = 4'h7;

   // ************************************************************
   // priority select codes
   // ************************************************************
   localparam logic [3:0] PSEL_TOF = 4'h0;
   localparam logic [3:0] PSEL_RSVD = 4'h5;
   localparam logic [3:0] PSEL_IRQ = 4'h6;
   localparam logic [3:0] PSEL_PERIOD = 4'h7;
   localparam logic [3:0] PSEL_IC1 = 4'h8;

   // ************************************************************
   // maskable source indices, default order
   // ************************************************************
   localparam int NUM_MASK = 15;
   localparam logic [3:0] IDX_EXT = 4'h0;
   localparam logic [3:0] IDX_PERIOD = 4'h1;
   localparam logic [3:0] IDX_IC1 = 4'h2;
   localparam logic [3:0] IDX_TOF = 4'hA;

   // ************************************************************
   // winner codes
   // ************************************************************
   localparam logic [4:0] SRC_POR = 5'h00;
   localparam logic [4:0] SRC_CLKMON = 5'h01;
   localparam logic [4:0] SRC_WDOG = 5'h02;
   localparam logic [4:0] SRC_XPIN = 5'h03;
   localparam logic [4:0] SRC_ILLOP = 5'h04;
   localparam logic [4:0] SRC_SWTRAP = 5'h05;
   localparam logic [4:0] SRC_MASK_BASE = 5'h06;

   // ************************************************************
   // vectors
   // ************************************************************
   localparam logic [15:0] VEC_POR = 16'hFFFE;
   localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
   localparam logic [15:0] VEC_WDOG = 16'hFFFA;
   localparam logic [15:0] VEC_ILLOP = 16'hFFF8;
   localparam logic [15:0] VEC_SWTRAP = 16'hFFF6;
   localparam logic [15:0] VEC_XPIN = 16'hFFF4;
   localparam logic [15:0] VEC_MASK_TOP = 16'hFFF2;
   localparam logic [3:0] VEC_SPECIAL_HI = 4'hB;

   typedef enum logic [1:0]
   {
      PH_CATCH = 2'b01,
      PH_RUN = 2'b10
   } phase_t;

   typedef struct packed
   {
      phase_t phase;
      logic boot_rd;
      logic spec;
      logic mode_a;
      logic vis;
      logic [3:0] psel;
      logic edge_mode;
      logic pin_prev;
      logic pin_latch;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic win_valid;
      logic win_reset;
      logic [4:0] win_src;
      logic [15:0] win_vec;
      logic read_vis;
      logic e_drive;
   } state_t;

endpackage: resolver_pkg

// ==== logic/interrupt_priority_resolver.sv ====
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns

// How it works
// - resets, watchdog, pin, traps in fixed order
// - maskable sources default order, pin first
// - selected source rises above all other maskable sources
// - codes 0000-0100 promote timer, accumulator, serial
// - 0101 and 0110 pin, 0111 periodic
// - codes 1000-1111 promote capture/compare channels
// - promoted source still gated by masks
// - promotion never changes any vector
// - select field writable only while masked
// - select field resets to 0110
// - external pin level-sensitive after reset
// - special flag takes inverted mode pin b
// - mode a flag takes mode pin a
// - special-mode writes to flags change mode
// - boot read bit writable only in special
// - expanded modes: visibility shows internal reads
// - single/boot modes: visibility gates e clock
// - upper nibble reset value follows mode
// - maskable requests only while mask clear
// - winner vector given for highest pending
module interrupt_priority_resolver
   import resolver_pkg::*;
#(
   parameter int ADDR_W = 16
)
(
   input logic pclk,
   input logic presetn,
   input logic clk_en,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [ADDR_W-1:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input logic mode_pin_a,
   input logic mode_pin_b,
   input logic global_mask,
   input logic x_mask,
   input logic por_req,
   input logic clock_monitor_req,
   input logic operating_watchdog_req,
   input logic nonmaskable_pin_interrupt_n,
   input logic illegal_opcode_req,
   input logic software_trap_req,
   input logic irq_pin_n,
   input logic [NUM_MASK-1:1] periph_flag,
   input logic [NUM_MASK-1:1] periph_enable,
   input logic vector_fetch,
   output logic winner_valid,
   output logic winner_is_reset,
   output logic [4:0] winner_source,
   output logic [15:0] winner_vector,
   output logic boot_rom_read_bit,
   output logic special_mode_flag,
   output logic mode_a_flag,
   output logic visibility_control_bit,
   output logic read_visibility_en,
   output logic e_clock_drive
);

   // ************************************************************
   // decode helpers
   // ************************************************************
   // 0 none, 1 control, 2 pin sense, 3 status
   function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
      logic [1:0] r;
      r = 2'h0;
      if (a == ADDR_W'(CTRL_ADDR))
      begin
         r = 2'h1;
      end
      else if (a == ADDR_W'(SENSE_ADDR))
      begin
         r = 2'h2;
      end
      else if (a == ADDR_W'(STATUS_ADDR))
      begin
         r = 2'h3;
      end
      return r;
   endfunction: reg_sel

   // select code to maskable index
   function automatic logic [3:0] promo_idx(input logic [3:0] code);
      logic [3:0] r;
      r = IDX_EXT;
      unique case (code)
         PSEL_RSVD, PSEL_IRQ: r = IDX_EXT;
         PSEL_PERIOD: r = IDX_PERIOD;
         default:
         begin
            if (code >= PSEL_IC1)
            begin
               r = IDX_IC1 + (code - PSEL_IC1);
            end
            else
            begin
               r = IDX_TOF + (code - PSEL_TOF);
            end
         end
      endcase
      return r;
   endfunction: promo_idx

   // fixed vector of a maskable index
   function automatic logic [15:0] vec_of(input logic [3:0] idx);
      return VEC_MASK_TOP - {11'h000, idx, 1'b0};
   endfunction: vec_of

   // lowest set index, found flag on top
   function automatic logic [4:0] lowest(input logic [NUM_MASK-1:0] r);
      logic [4:0] res;
      res = 5'h00;
      for (int i = NUM_MASK - 1; i >= 0; i--)
      begin
         if (r[i])
         begin
            res = {1'b1, 4'(i)};
         end
      end
      return res;
   endfunction: lowest

   // ************************************************************
   // maskable request gating
   // ************************************************************
   logic [NUM_MASK-1:0] mreq;
   state_t s_r;
   state_t s_nxt;

   assign mreq[0] = (s_r.edge_mode ? s_r.pin_latch : ~irq_pin_n)
                    & ~global_mask;

   genvar g;
   generate
      for (g = 1; g < NUM_MASK; g++)
      begin : gate
         assign mreq[g] = periph_flag[g] & periph_enable[g]
                          & ~global_mask;
      end
   endgenerate

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      logic access;
      logic [1:0] sel;
      logic [3:0] pidx;
      logic [4:0] low;
      logic [3:0] widx;
      logic fall;
      logic clr;
      logic [15:0] rvec;
      access = psel & penable;
      sel = reg_sel(paddr);
      pidx = promo_idx(s_r.psel);
      low = lowest(mreq);
      widx = low[3:0];
      fall = s_r.pin_prev & ~irq_pin_n;
      clr = 1'b0;
      rvec = 16'h0000;
      s_nxt = s_r;

      // bus slave: one wait cycle, commit on ready edge
      if (s_r.pready)
      begin
         s_nxt.pready = 1'b0;
         s_nxt.pslverr = 1'b0;
         s_nxt.prdata = 32'h0000_0000;
         if (access && pwrite && !s_r.pslverr)
         begin
            if (sel == 2'h1)
            begin
               if (global_mask)
               begin
                  s_nxt.psel = pwdata[3:0];
               end
               s_nxt.vis = pwdata[BIT_VIS];
               if (s_r.spec)
               begin
                  s_nxt.spec = pwdata[BIT_SPEC];
                  s_nxt.mode_a = pwdata[BIT_MODE_A];
                  s_nxt.boot_rd = pwdata[BIT_BOOT];
               end
               if (!s_nxt.spec)
               begin
                  s_nxt.boot_rd = 1'b0;
               end
            end
            else if (sel == 2'h2)
            begin
               s_nxt.edge_mode = pwdata[BIT_EDGE];
            end
         end
      end
      else if (access)
      begin
         s_nxt.pready = 1'b1;
         s_nxt.pslverr = (sel == 2'h0);
         unique case (sel)
            2'h1:
            begin
               s_nxt.prdata[7:0] = {s_r.boot_rd, s_r.spec,
                                    s_r.mode_a, s_r.vis, s_r.psel};
            end
            2'h2:
            begin
               s_nxt.prdata[BIT_EDGE] = s_r.edge_mode;
               s_nxt.prdata[BIT_LATCH] = s_r.pin_latch;
            end
            2'h3:
            begin
               s_nxt.prdata[BIT_WVALID] = s_r.win_valid;
               s_nxt.prdata[BIT_WRESET] = s_r.win_reset;
               s_nxt.prdata[SRC_LSB+4:SRC_LSB] = s_r.win_src;
               s_nxt.prdata[15:0] = s_r.win_vec;
            end
            2'h0:
            begin
               s_nxt.prdata = 32'h0000_0000;
            end
         endcase
      end

      // mode capture at first edge after reset release
      if (s_r.phase == PH_CATCH)
      begin
         s_nxt.phase = PH_RUN;
         s_nxt.spec = ~mode_pin_b;
         s_nxt.mode_a = mode_pin_a;
         unique case ({~mode_pin_b, mode_pin_a})
            2'b00:
            begin
               {s_nxt.boot_rd, s_nxt.spec, s_nxt.mode_a, s_nxt.vis} =
                  MODE_RST_SINGLE;
            end
            2'b01:
            begin
               {s_nxt.boot_rd, s_nxt.spec, s_nxt.mode_a, s_nxt.vis} =
                  MODE_RST_EXPANDED;
            end
            2'b10:
            begin
               {s_nxt.boot_rd, s_nxt.spec, s_nxt.mode_a, s_nxt.vis} =
                  MODE_RST_BOOT;
            end
            2'b11:
            begin
               {s_nxt.boot_rd, s_nxt.spec, s_nxt.mode_a, s_nxt.vis} =
                  MODE_RST_TEST;
            end
         endcase
      end

      // edge-mode pin latch, new edge beats clear
      s_nxt.pin_prev = irq_pin_n;
      clr = vector_fetch && s_r.win_valid &&
            (s_r.win_src == SRC_MASK_BASE + 5'(IDX_EXT));
      s_nxt.pin_latch = (s_r.edge_mode & fall) | (s_r.pin_latch & ~clr);

      // arbitration: non-maskable first
      s_nxt.win_valid = 1'b1;
      s_nxt.win_reset = 1'b0;
      if (por_req)
      begin
         s_nxt.win_reset = 1'b1;
         s_nxt.win_src = SRC_POR;
         rvec = VEC_POR;
      end
      else if (clock_monitor_req)
      begin
         s_nxt.win_reset = 1'b1;
         s_nxt.win_src = SRC_CLKMON;
         rvec = VEC_CLKMON;
      end
      else if (operating_watchdog_req)
      begin
         s_nxt.win_reset = 1'b1;
         s_nxt.win_src = SRC_WDOG;
         rvec = VEC_WDOG;
      end
      else if (!nonmaskable_pin_interrupt_n && !x_mask)
      begin
         s_nxt.win_src = SRC_XPIN;
         rvec = VEC_XPIN;
      end
      else if (illegal_opcode_req)
      begin
         s_nxt.win_src = SRC_ILLOP;
         rvec = VEC_ILLOP;
      end
      else if (software_trap_req)
      begin
         s_nxt.win_src = SRC_SWTRAP;
         rvec = VEC_SWTRAP;
      end
      else if (mreq[pidx])
      begin
         s_nxt.win_src = SRC_MASK_BASE + 5'(pidx);
         rvec = vec_of(pidx);
      end
      else if (low[4])
      begin
         s_nxt.win_src = SRC_MASK_BASE + 5'(widx);
         rvec = vec_of(widx);
      end
      else
      begin
         s_nxt.win_valid = 1'b0;
         s_nxt.win_src = 5'h00;
      end
      if (s_nxt.win_reset && s_nxt.spec)
      begin
         rvec[15:12] = VEC_SPECIAL_HI;
      end
      s_nxt.win_vec = rvec;

      // pin control from mode and visibility
      s_nxt.read_vis = s_nxt.mode_a & s_nxt.vis;
      s_nxt.e_drive = s_nxt.mode_a | ~s_nxt.vis;
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_r <= '{phase: PH_CATCH,
                  boot_rd: 1'b0,
                  spec: 1'b0,
                  mode_a: 1'b0,
                  vis: 1'b0,
                  psel: PSEL_RST,
                  edge_mode: 1'b0,
                  pin_prev: 1'b1,
                  pin_latch: 1'b0,
                  pready: 1'b0,
                  pslverr: 1'b0,
                  prdata: 32'h0000_0000,
                  win_valid: 1'b0,
                  win_reset: 1'b0,
                  win_src: 5'h00,
                  win_vec: 16'h0000,
                  read_vis: 1'b0,
                  e_drive: 1'b1};
      end
      else if (clk_en)
      begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign winner_valid = s_r.win_valid;
   assign winner_is_reset = s_r.win_reset;
   assign winner_source = s_r.win_src;
   assign winner_vector = s_r.win_vec;
   assign boot_rom_read_bit = s_r.boot_rd;
   assign special_mode_flag = s_r.spec;
   assign mode_a_flag = s_r.mode_a;
   assign visibility_control_bit = s_r.vis;
   assign read_visibility_en = s_r.read_vis;
   assign e_clock_drive = s_r.e_drive;

endmodule: interrupt_priority_resolver

// ==== testbench/cpu_model.sv ====
`timescale 1ns/1ns
// ********************
// core and mask model
// ********************
module cpu_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic set_mask,
   input wire logic take,
   input wire logic [15:0] winner_vector,
   output logic global_mask,
   output logic vector_fetch,
   output logic [15:0] fetched_vec
);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         global_mask <= 1'b1;
         vector_fetch <= 1'b0;
         fetched_vec <= 16'h0000;
      end
      else
      begin
         global_mask <= set_mask;
         vector_fetch <= take;
         if (take)
            fetched_vec <= winner_vector;
      end
   end
endmodule: cpu_model

// ==== testbench/resolver_checker_props.sv ====
`timescale 1ns/1ns
// ********************
// winner and bus checks
// ********************
module resolver_checker
   import resolver_pkg::*;
(
   input logic pclk,
   input logic presetn,
   input logic clk_en,
   input logic psel,
   input logic penable,
   input logic pready,
   input logic global_mask,
   input logic x_mask,
   input logic por_req,
   input logic clock_monitor_req,
   input logic operating_watchdog_req,
   input logic nonmaskable_pin_interrupt_n,
   input logic illegal_opcode_req,
   input logic software_trap_req,
   input logic winner_valid,
   input logic winner_is_reset,
   input logic [4:0] winner_source,
   input logic [15:0] winner_vector,
   input logic boot_rom_read_bit,
   input logic special_mode_flag,
   input logic mode_a_flag,
   input logic visibility_control_bit,
   input logic read_visibility_en,
   input logic e_clock_drive
);
   logic nm_any;
   logic xpin_only;
   assign nm_any = por_req | clock_monitor_req | operating_watchdog_req
      | (!nonmaskable_pin_interrupt_n & !x_mask) | illegal_opcode_req
      | software_trap_req;
   assign xpin_only = !por_req & !clock_monitor_req
      & !operating_watchdog_req & !nonmaskable_pin_interrupt_n & !x_mask;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_por;
      clk_en && por_req |=> winner_is_reset && winner_source == SRC_POR;
   endproperty
   a_por: assert property (p_por) else $error("reset not first");
   property p_xpin;
      clk_en && xpin_only |=> !winner_is_reset && winner_source == SRC_XPIN;
   endproperty
   a_xpin: assert property (p_xpin) else $error("pin not won");
   property p_masked;
      clk_en && global_mask && !nm_any |=> !winner_valid;
   endproperty
   a_masked: assert property (p_masked) else $error("masked won");
   property p_vec;
      winner_valid && winner_source >= SRC_MASK_BASE |-> winner_vector
         == VEC_MASK_TOP - {10'h000, winner_source - SRC_MASK_BASE, 1'b0};
   endproperty
   a_vec: assert property (p_vec) else $error("vector wrong");
   property p_boot;
      !special_mode_flag |-> !boot_rom_read_bit;
   endproperty
   a_boot: assert property (p_boot) else $error("boot bit set");
   property p_vis;
      $stable(mode_a_flag) && $stable(visibility_control_bit) |->
         read_visibility_en == (mode_a_flag && visibility_control_bit)
         && e_clock_drive == (mode_a_flag || !visibility_control_bit);
   endproperty
   a_vis: assert property (p_vis) else $error("visibility wrong");
   property p_answer;
      clk_en && psel && penable && !pready |=> pready;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_pulse;
      clk_en && pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ready held");
   c_reset: cover property (winner_is_reset);
   c_mask: cover property (winner_valid && winner_source > SRC_MASK_BASE);
   c_bus: cover property (pready && special_mode_flag);
endmodule: resolver_checker

bind interrupt_priority_resolver resolver_checker u_resolver_checker (.*);

// ==== testbench/interrupt_priority_resolver_tb.sv ====
`timescale 1ns/1ns
// ********************
// bench
// ********************
module interrupt_priority_resolver_tb
   import resolver_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, x_mask = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, take = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic mode_pin_a = 1'b0, mode_pin_b = 1'b0, set_mask = 1'b1;
   logic por_req = 1'b0, clock_monitor_req = 1'b0, irq_pin_n = 1'b1;
   logic operating_watchdog_req = 1'b0, illegal_opcode_req = 1'b0;
   logic software_trap_req = 1'b0, nonmaskable_pin_interrupt_n = 1'b1;
   logic [14:1] periph_flag = 14'h0000, periph_enable = 14'h0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, global_mask, vector_fetch, winner_valid;
   logic winner_is_reset, boot_rom_read_bit, special_mode_flag;
   logic mode_a_flag, visibility_control_bit, read_visibility_en;
   logic e_clock_drive;
   logic [4:0] winner_source;
   logic [15:0] winner_vector, fetched_vec;
   logic [15:0] nm_vec [6] = '{16'hbffe, 16'hbffc, 16'hbffa, 16'hfff4,
      16'hfff8, 16'hfff6};
   logic [7:0] mode_exp [4] = '{8'h06, 8'h26, 8'hc6, 8'h76};
   logic [3:0] mb = 4'b0011, ma = 4'b1010;
   int n_errors = 0, samples_checked = 0, cycles = 0, idx;

   interrupt_priority_resolver u_interrupt_priority_resolver (.*);
   cpu_model u_cpu_model (.*);

   always #25 pclk = ~pclk;

   task automatic end_sim();
      $display("checks=%0d errors=%0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask: end_sim

   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_errors++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask: chk

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask: tick

   task automatic apb(input logic w, input logic [15:0] a,
      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1)
         n_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask: apb

   task automatic rd_exp(input logic [15:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask: rd_exp

   task automatic set_nm(input logic [5:0] v);
      por_req <= v[0];
      clock_monitor_req <= v[1];
      operating_watchdog_req <= v[2];
      nonmaskable_pin_interrupt_n <= !v[3];
      illegal_opcode_req <= v[4];
      software_trap_req <= v[5];
   endtask: set_nm

   task automatic win(input logic [4:0] s, input logic [15:0] v);
      tick(3);
      take <= 1'b1;
      @(posedge pclk);
      take <= 1'b0;
      @(posedge pclk);
      chk({27'h000_0000, winner_source}, {27'h000_0000, s});
      chk({16'h0000, fetched_vec}, {16'h0000, v});
   endtask: win

   task automatic do_reset(input logic b, input logic a);
      presetn <= 1'b0;
      mode_pin_b <= b;
      mode_pin_a <= a;
      tick(4);
      presetn <= 1'b1;
      tick(2);
   endtask: do_reset

   function automatic int prom(input int c);
      if (c < 5)
         return c + 10;
      if (c < 7)
         return 0;
      return c - 6;
   endfunction: prom

   initial
   begin
      do_reset(1'b0, 1'b1);
      rd_exp(SENSE_ADDR, 32'h0000_0000);
      apb(1'b0, 16'h1048, 32'h0000_0000);
      chk({31'h0000_0000, err}, 32'h0000_0001);
      for (idx = 0; idx < 6; idx++)
      begin
         set_nm(6'h3f << idx);
         win(5'(idx), nm_vec[idx]);
      end
      set_nm(6'h08);
      x_mask <= 1'b1;
      tick(3);
      chk({31'h0000_0000, winner_valid}, 32'h0000_0000);
      x_mask <= 1'b0;
      set_nm(6'h00);
      apb(1'b1, CTRL_ADDR, 32'h0000_00f6);
      rd_exp(CTRL_ADDR, 32'h0000_00f6);
      chk({31'h0000_0000, read_visibility_en}, 32'h0000_0001);
      apb(1'b1, CTRL_ADDR, 32'h0000_0006);
      rd_exp(CTRL_ADDR, 32'h0000_0006);
      apb(1'b1, CTRL_ADDR, 32'h0000_00f6);
      rd_exp(CTRL_ADDR, 32'h0000_0016);
      chk({31'h0000_0000, e_clock_drive}, 32'h0000_0000);
      periph_flag <= 14'h3fff;
      periph_enable <= 14'h3fff;
      irq_pin_n <= 1'b0;
      for (idx = 0; idx < 16; idx++)
      begin
         set_mask <= 1'b1;
         tick(2);
         apb(1'b1, CTRL_ADDR, {24'h00_0000, 4'h1, 4'(idx)});
         set_mask <= 1'b0;
         win(SRC_MASK_BASE + 5'(prom(idx)),
            16'hfff2 - 16'(2 * prom(idx)));
      end
      apb(1'b1, CTRL_ADDR, 32'h0000_0013);
      rd_exp(CTRL_ADDR, 32'h0000_001f);
      set_mask <= 1'b1;
      tick(2);
      apb(1'b1, CTRL_ADDR, 32'h0000_0018);
      periph_enable <= 14'h3ffd;
      set_mask <= 1'b0;
      win(SRC_MASK_BASE, 16'hfff2);
      set_mask <= 1'b1;
      tick(3);
      chk({31'h0000_0000, winner_valid}, 32'h0000_0000);
      apb(1'b1, CTRL_ADDR, 32'h0000_0016);
      irq_pin_n <= 1'b1;
      periph_enable <= 14'h3fff;
      set_mask <= 1'b0;
      for (idx = 1; idx < 15; idx++)
      begin
         periph_flag <= 14'h3fff << (idx - 1);
         win(SRC_MASK_BASE + 5'(idx), 16'hfff2 - 16'(2 * idx));
      end
      periph_flag <= 14'h0000;
      apb(1'b1, SENSE_ADDR, 32'h0000_0001);
      irq_pin_n <= 1'b0;
      tick(2);
      irq_pin_n <= 1'b1;
      rd_exp(SENSE_ADDR, 32'h0000_0003);
      rd_exp(STATUS_ADDR, 32'h8006_fff2);
      win(SRC_MASK_BASE, 16'hfff2);
      rd_exp(SENSE_ADDR, 32'h0000_0001);
      clk_en <= 1'b0;
      set_nm(6'h10);
      tick(3);
      chk({31'h0000_0000, winner_valid}, 32'h0000_0000);
      clk_en <= 1'b1;
      tick(2);
      chk({27'h000_0000, winner_source}, {27'h000_0000, SRC_ILLOP});
      set_nm(6'h00);
      for (idx = 0; idx < 4; idx++)
      begin
         do_reset(mb[idx], ma[idx]);
         rd_exp(CTRL_ADDR, {24'h00_0000, mode_exp[idx]});
      end
      end_sim();
   end
endmodule: interrupt_priority_resolver_tb
